// [common/phyps_pkg.sv]
/*
  Constants for the pair wiring status and low-power support map registers:
  register addresses, field positions, fixed field values and reset words.
  Assumes a 16-bit management address space and 16-bit register data.
*/
package phyps_pkg;

  // ------------------------------------------------------------------
  // Register space
  // ------------------------------------------------------------------
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam logic [15:0] WIRING_ADDR   = 16'h001f;
  localparam logic [15:0] LPMAP_ADDR    = 16'h8000;
  localparam logic [15:0] UNMAPPED_DATA = 16'h0000;

  // ------------------------------------------------------------------
  // Pair wiring status layout
  // ------------------------------------------------------------------
  localparam logic [15:0] WIRING_RESET  = 16'h03fc;
  localparam int          WIR_RSVD_HI   = 15;
  localparam int          WIR_SWAP      = 14;
  localparam int          WIR_POL_MSB   = 13;
  localparam int          WIR_POL_LSB   = 10;
  localparam int          WIR_FILL_MSB  = 9;
  localparam int          WIR_FILL_LSB  = 1;
  localparam logic [8:0]  WIR_FILL_VAL  = 9'h1fe;
  localparam int          WIR_ACQ_ERR   = 0;
  localparam int          NUM_PAIRS     = 4;

  // ------------------------------------------------------------------
  // Low-power support map layout (fixed content)
  // ------------------------------------------------------------------
  localparam logic [15:0] LPMAP_RESET   = 16'h0006;
  localparam int          LPM_KR        = 6;
  localparam int          LPM_KX4       = 5;
  localparam int          LPM_KX        = 4;
  localparam int          LPM_TEN_T     = 3;
  localparam int          LPM_GIG       = 2;
  localparam int          LPM_FAST      = 1;

endpackage : phyps_pkg

// [hdl/phyps_sticky_flag.sv]
/*
  Sticky flag: set by a hardware event pulse, held until a clear pulse.
  Assumes set and clear pulses are synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module phyps_sticky_flag
  import phyps_pkg::*;
(
  input  wire logic CLOCK_I,
  input  wire logic NRST_I,
  input  wire logic set_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
  } phyps_flag_state_t;

  phyps_flag_state_t st;
  phyps_flag_state_t next_st;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // Set beats clear so an event in the clearing cycle is never lost
  always_comb begin
    next_st = st;
    if (set_i) begin
      next_st.flag = 1'b1;
    end else if (clear_i) begin
      next_st.flag = 1'b0;
    end
  end

  // State register
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag_o = st.flag;

endmodule : phyps_sticky_flag

`default_nettype wire

// [hdl/phyps_regs.sv]
/*
  Pair wiring status and low-power support map registers of a gigabit
  copper transceiver, read by a management station over a simple
  register port (address, read strobe, write strobe, data).
  Assumes the correction and descrambler logic drive the status inputs
  synchronously to CLOCK_I; read data appears one cycle after the strobe.
*/
// Contract
// - Report corrected pair 2/3 swap in bit 14
// - Per-pair polarity inversion bits 13 down to 10
// - Set bit 0 on failed gigabit descrambler lock
// - Error flag holds until later successful lock
// - Wiring register resets to 0x03FC, fixed fills
// - Support map bit 2 always reads one
// - Support map bit 1 always reads one
// - Support map bits 6 to 3 read zero
// - Support map at 0x8000 reads 0x0006
// - Support map mirrors standard PCS capability register
`timescale 1ns/1ps
`default_nettype none

module phyps_regs
  import phyps_pkg::*;
#(
  parameter int PAIRS = NUM_PAIRS
)
(
  input  wire logic              CLOCK_I,
  input  wire logic              NRST_I,
  // Management register port
  input  wire logic [ADDR_W-1:0] REG_ADDR_I,
  input  wire logic              REG_RD_I,
  input  wire logic              REG_WR_I,
  input  wire logic [DATA_W-1:0] REG_WDATA_I,
  output logic      [DATA_W-1:0] REG_RDATA_O,
  output logic                   REG_RVALID_O,
  // Wiring correction status from the receive path
  input  wire logic              PAIR_SWAP_I,
  input  wire logic [PAIRS-1:0]  PAIR_POLARITY_I,
  input  wire logic              GIG_LOCK_FAIL_I,
  input  wire logic              GIG_LOCK_OK_I
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic              swap;
    logic [PAIRS-1:0]  pol;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
  } phyps_state_t;

  phyps_state_t      st;
  phyps_state_t      next_st;
  logic              gig_descrambler_lock_error;
  logic [DATA_W-1:0] wiring_word;
  logic [DATA_W-1:0] lpmap_word;
  logic              wr_seen;

  // Writes carry no meaning here; the strobe is seen only by the checks
  assign wr_seen = REG_WR_I & (|REG_WDATA_I);

  // ------------------------------------------------------------------
  // Latched descrambler acquisition error
  // ------------------------------------------------------------------
  // Only the lock logic clears it; software has no path to it
  phyps_sticky_flag u_lock_err (
    .CLOCK_I (CLOCK_I),
    .NRST_I  (NRST_I),
    .set_i   (GIG_LOCK_FAIL_I),
    .clear_i (GIG_LOCK_OK_I),
    .flag_o  (gig_descrambler_lock_error)
  );

  // ------------------------------------------------------------------
  // Register words
  // ------------------------------------------------------------------
  // Wiring word; reserved fill holds its fixed pattern so reset reads 0x03FC
  always_comb begin
    wiring_word                             = '0;
    wiring_word[WIR_RSVD_HI]                = 1'b0;
    wiring_word[WIR_SWAP]                   = st.swap;
    wiring_word[WIR_POL_MSB:WIR_POL_LSB]    = st.pol;
    wiring_word[WIR_FILL_MSB:WIR_FILL_LSB]  = WIR_FILL_VAL;
    wiring_word[WIR_ACQ_ERR]                = gig_descrambler_lock_error;
  end

  // Support map is pure constant, same layout as the standard PCS one
  always_comb begin
    lpmap_word            = '0;
    lpmap_word[LPM_KR]    = 1'b0;
    lpmap_word[LPM_KX4]   = 1'b0;
    lpmap_word[LPM_KX]    = 1'b0;
    lpmap_word[LPM_TEN_T] = 1'b0;
    lpmap_word[LPM_GIG]   = 1'b1;
    lpmap_word[LPM_FAST]  = 1'b1;
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  // Status levels are sampled each cycle; writes never touch any field
  always_comb begin
    next_st        = st;
    next_st.swap   = PAIR_SWAP_I;
    next_st.pol    = PAIR_POLARITY_I;
    next_st.rvalid = REG_RD_I;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        WIRING_ADDR: begin
          next_st.rdata = wiring_word;
        end
        LPMAP_ADDR: begin
          next_st.rdata = lpmap_word;
        end
        default: begin
          next_st.rdata = UNMAPPED_DATA;
        end
      endcase
    end
  end

  // State register; flags start cleared
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA_O  = st.rdata;
  assign REG_RVALID_O = st.rvalid;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_read_wiring;
    REG_RD_I && (REG_ADDR_I == WIRING_ADDR);
  endsequence

  sequence s_read_lpmap;
    REG_RD_I && (REG_ADDR_I == LPMAP_ADDR);
  endsequence

  // Swap seen by the receive path shows up in a read two cycles on
  chk_swap_reported: assert property (
    PAIR_SWAP_I ##1 s_read_wiring |=> REG_RVALID_O && REG_RDATA_O[WIR_SWAP]
  ) else $error("pair swap not reported in bit 14");

  // Polarity bits follow the pair inputs with the same two-cycle lag
  chk_polarity_reported: assert property (
    ##1 s_read_wiring |=>
      REG_RDATA_O[WIR_POL_MSB:WIR_POL_LSB] == $past(PAIR_POLARITY_I, 2)
  ) else $error("polarity bits do not follow the pairs");

  // A cleared swap input must not leave a stale swap bit behind
  chk_swap_cleared: assert property (
    !PAIR_SWAP_I ##1 s_read_wiring |=> !REG_RDATA_O[WIR_SWAP]
  ) else $error("pair swap bit stuck after swap cleared");

  // A failed lock is visible in the very next read
  chk_lock_fail_set: assert property (
    GIG_LOCK_FAIL_I ##1 s_read_wiring |=> REG_RDATA_O[WIR_ACQ_ERR]
  ) else $error("descrambler error not set after failed lock");

  // Nothing but a good lock may drop the latched error
  chk_lock_err_holds: assert property (
    gig_descrambler_lock_error && !GIG_LOCK_OK_I |=> gig_descrambler_lock_error
  ) else $error("descrambler error dropped without a good lock");

  // A good lock clears the error unless a new failure follows at once
  chk_lock_ok_clears: assert property (
    GIG_LOCK_OK_I && !GIG_LOCK_FAIL_I |=> !gig_descrambler_lock_error [*2]
      or (##1 $rose(gig_descrambler_lock_error))
  ) else $error("good lock did not clear descrambler error");

  // Reserved fill and the top reserved bit never move
  chk_wiring_fill: assert property (
    s_read_wiring |=> REG_RDATA_O[WIR_FILL_MSB:WIR_FILL_LSB] == WIR_FILL_VAL
      && !REG_RDATA_O[WIR_RSVD_HI]
  ) else $error("wiring reserved fill wrong");

  // Whole support map word is the fixed reset word
  chk_lpmap_value: assert property (
    s_read_lpmap |=> REG_RVALID_O && REG_RDATA_O == LPMAP_RESET
  ) else $error("support map does not read 0x0006");

  // Supported and unsupported rates, bit by bit
  chk_lpmap_bits: assert property (
    s_read_lpmap |=> REG_RDATA_O[LPM_GIG] && REG_RDATA_O[LPM_FAST]
      && (REG_RDATA_O[LPM_KR:LPM_TEN_T] == 4'h0)
  ) else $error("support map capability bits wrong");

  // Writes never reach the latched error
  chk_write_ignored: assert property (
    REG_WR_I && !GIG_LOCK_FAIL_I && !GIG_LOCK_OK_I |=>
      $stable(gig_descrambler_lock_error)
  ) else $error("write changed a read-only field");

  // Writes never disturb the last read answer either
  chk_write_keeps_data: assert property (
    REG_WR_I && !REG_RD_I |=> $stable(REG_RDATA_O)
  ) else $error("write changed the read data");

  // Addresses outside the two registers answer with zero
  chk_unmapped_zero: assert property (
    REG_RD_I && (REG_ADDR_I != WIRING_ADDR) && (REG_ADDR_I != LPMAP_ADDR)
      |=> REG_RDATA_O == UNMAPPED_DATA
  ) else $error("unmapped read not zero");

  // A write strobe with nonzero data and no read never raises the answer flag
  chk_write_no_answer: assert property (
    wr_seen && !REG_RD_I |=> !REG_RVALID_O
  ) else $error("write produced a read answer");

  // One answer cycle for every strobe cycle, and none otherwise
  chk_answer_timing: assert property (
    REG_RVALID_O == $past(REG_RD_I)
  ) else $error("read answer not one cycle after the strobe");

endmodule : phyps_regs

`default_nettype wire

// [bench/phyps_mgmt_station.sv]
/*
  Management station model: issues register reads and writes.
  Assumes the fixed one-cycle read answer of the register port.
*/
`timescale 1ns/1ps
`default_nettype none

module phyps_mgmt_station
  import phyps_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic              rvalid_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic                   rd_o,
  output logic                   wr_o,
  output logic      [DATA_W-1:0] wdata_o
);
  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  // Lines start at zero; after a cycle the address, and after a write the data, show the inverse
  initial begin
    addr_o  = 16'h0000;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 16'h0000;
  end

  // One read: strobe for one cycle, take the answer a cycle later
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(negedge clock_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clock_i);
    rd_o   = 1'b0;
    addr_o = ~a;
    v      = rvalid_i;
    d      = rdata_i;
  endtask : rd

  // One write: the block must ignore it
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clock_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : wr
endmodule : phyps_mgmt_station
`default_nettype wire

// [bench/phy_pair_status_and_eee_caps_tb.sv]
/*
  Self-checking bench for the wiring status and support map registers.
  Assumes the management station model in its own file.
*/
`timescale 1ns/1ps
`default_nettype none

module phy_pair_status_and_eee_caps_tb;
  import phyps_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] addr;
  logic        rd;
  logic        wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  logic        swap = 1'b0;
  logic [3:0]  pol = 4'h0;
  logic        fail = 1'b0;
  logic        ok = 1'b0;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cycles = 0;
  // Inputs {swap, pol[3:0]} beside the wiring word they should read as
  logic [20:0] rows [7] = '{{5'h00, 16'h03fc}, {5'h10, 16'h43fc}, {5'h01, 16'h07fc},
                            {5'h02, 16'h0bfc}, {5'h04, 16'h13fc}, {5'h08, 16'h23fc},
                            {5'h1f, 16'h7ffc}};

  // --------------------------------------------------------------
  // Clock, parts and helpers
  // --------------------------------------------------------------
  always #10 clk = ~clk;

  phyps_mgmt_station mgmt (.clock_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
    .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));

  phyps_regs dut (.CLOCK_I(clk), .NRST_I(nrst), .REG_ADDR_I(addr), .REG_RD_I(rd),
    .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .PAIR_SWAP_I(swap), .PAIR_POLARITY_I(pol), .GIG_LOCK_FAIL_I(fail),
    .GIG_LOCK_OK_I(ok));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // A read must be answered with valid high as well as the right word
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    mgmt.rd(a, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask : rdchk

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // A hang ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end

  // Pulse one status input for a cycle; both at once checks set-wins
  task automatic pulse(input logic f, input logic k);
    @(negedge clk);
    fail = f;
    ok   = k;
    @(negedge clk);
    fail = 1'b0;
    ok   = 1'b0;
  endtask : pulse

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    rdchk(WIRING_ADDR, 16'h03fc);
    rdchk(16'h8000, 16'h0006);
    rdchk(16'h0020, 16'h0000);
    // The answer flag stands for one cycle only
    @(negedge clk);
    check({15'h0000, rvalid}, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 7; i++) begin
      swap = rows[i][20];
      pol  = rows[i][19:16];
      rdchk(WIRING_ADDR, rows[i][15:0]);
    end
    swap = 1'b0;
    pol  = 4'h0;
    $display("wiring rows done");
    // Failure stands while the read is strobed: the very next read sees it
    @(negedge clk);
    fail = 1'b1;
    rdchk(16'h001f, 16'h03fd);
    fail = 1'b0;
    rdchk(16'h001f, 16'h03fd);
    mgmt.wr(16'h001f, 16'h0000);
    check({15'h0000, rvalid}, 16'h0000);
    mgmt.wr(16'h8000, 16'hffff);
    rdchk(16'h001f, 16'h03fd);
    rdchk(16'h8000, 16'h0006);
    pulse(1'b0, 1'b1);
    rdchk(16'h001f, 16'h03fc);
    pulse(1'b1, 1'b1);
    rdchk(16'h001f, 16'h03fd);
    $display("sticky error done");
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    check(rdata, 16'h0000);
    check({15'h0000, rvalid}, 16'h0000);
    nrst = 1'b1;
    rdchk(16'h001f, 16'h03fc);
    $display("second reset done");
    test_done();
  end
endmodule : phy_pair_status_and_eee_caps_tb
`default_nettype wire
